/* pkg/supply_monitor_pkg.sv */
// shared constants and types for the supply monitor flag logic
package supply_monitor_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hdf;
  localparam logic [7:0] CTRL_RESET = 8'hde;
  localparam int BIT_DIG_CMP = 7;
  localparam int BIT_ANA_CMP = 6;
  localparam int BIT_LOW_FLAG = 5;
  localparam int BIT_DTRIP_HI = 4;
  localparam int BIT_DTRIP_LO = 3;
  localparam int BIT_ATRIP_HI = 2;
  localparam int BIT_ATRIP_LO = 1;
  localparam int BIT_ENABLE = 0;
  // trip encodings, millivolts
  localparam int TRIP_00_MV = 4630;
  localparam int TRIP_01_MV = 3080;
  localparam int TRIP_10_MV = 2930;
  localparam int TRIP_11_MV = 2630;
  localparam int CLK_MHZ = 250;
  localparam int HOLD_MS = 250;
  localparam longint HOLD_CYCLES = longint'(HOLD_MS) * 1000 * CLK_MHZ;
  localparam int GLITCH_CYCLES = 4;
  localparam int HOLD_W = 27;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FAULT = 2'b01,
    ST_HOLD = 2'b10
  } mon_state_t;
endpackage

/* pkg/cmp_filter_if.sv */
// carrier between top and glitch filter
`timescale 1ns/1ns
interface cmp_filter_if;
  logic dig_raw;
  logic ana_raw;
  logic dig_good;
  logic ana_good;
  modport top (output dig_raw, output ana_raw, input dig_good, input ana_good);
  modport filt (input dig_raw, input ana_raw, output dig_good, output ana_good);
endinterface

/* core/cmp_glitch_filter.sv */
// glitch filter for the two comparator outputs
`timescale 1ns/1ns
module cmp_glitch_filter
  import supply_monitor_pkg::*;
#(
  parameter int STABLE = GLITCH_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  cmp_filter_if.filt f
);
  logic [1:0] raw;
  logic [1:0] good;
  logic [7:0] cnt [2];
  assign raw = {f.ana_raw, f.dig_raw};
  assign f.dig_good = good[0];
  assign f.ana_good = good[1];
  // output follows raw only after raw differs for STABLE cycles
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        good[i] <= 1'b1;
        cnt[i] <= 8'h00;
      end
      else if (raw[i] == good[i])
        cnt[i] <= 8'h00;
      else if (cnt[i] == 8'(STABLE - 1))
      begin
        good[i] <= raw[i];
        cnt[i] <= 8'h00;
      end
      else
        cnt[i] <= cnt[i] + 8'h01;
    end
  end
endmodule

/* core/supply_monitor_flag_logic.sv */
// supply monitor control register, low-supply flag and hold-off timer
// Operation
// - when enabled, watch both supplies against one of four selectable trips.
// - interrupt request raised only when flag set and core enable bit set.
// - after both comparators recover and stay high, run hold-off then clear flag.
// - hardware clears the flag only after the failing supply is good for at least 250 ms.
// - short comparator glitches are filtered and cannot set the flag.
// - bit 7 is read-only live digital comparator state.
// - bit 6 is read-only live analog comparator state.
// - flag bit 5 is set whenever either filtered comparator is low.
// - software may write the flag; clears ignored while a comparator is low.
// - bits 4:3 select digital trip level 4.63, 3.08, 2.93, 2.63 V.
// - bits 2:1 select analog trip level with the same encoding.
// - bit 0 enables the monitor when 1, disables when 0.
`timescale 1ns/1ns
module supply_monitor_flag_logic
  import supply_monitor_pkg::*;
#(
  parameter longint HOLD_COUNT = HOLD_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  output logic [7:0] sfr_rdata,
  input wire logic dig_supply_cmp,
  input wire logic ana_supply_cmp,
  input wire logic supply_irq_enable,
  output logic [1:0] digital_trip_select,
  output logic [1:0] analog_trip_select,
  output logic supply_monitor_enable,
  output logic supply_low_flag,
  output logic supply_irq
);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_COUNT - 1);

  cmp_filter_if cf ();
  mon_state_t state;
  mon_state_t next_state;
  logic [HOLD_W-1:0] hold_cnt;
  logic digital_supply_compare;
  logic analog_supply_compare;
  logic [4:0] ctrl_bits;
  logic [HOLD_W-1:0] good_run;

  // comparators are forced good while the monitor is disabled
  assign cf.dig_raw = dig_supply_cmp | ~ctrl_bits[BIT_ENABLE];
  assign cf.ana_raw = ana_supply_cmp | ~ctrl_bits[BIT_ENABLE];

  cmp_glitch_filter #(.STABLE(GLITCH_CYCLES)) u_filt (
    .clk(clk),
    .rst(rst),
    .f(cf)
  );

  // decode and status terms
  wire ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
  wire any_low = ~cf.dig_good | ~cf.ana_good;
  wire sw_flag = sfr_wdata[BIT_LOW_FLAG];
  wire hold_done = (state == ST_HOLD) && (hold_cnt == HOLD_LAST) && !any_low;
  wire [7:0] read_value = {digital_supply_compare, analog_supply_compare,
                           supply_low_flag, ctrl_bits[4:1], ctrl_bits[0]};

  // flag state machine
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (any_low)
          next_state = ST_FAULT;
      ST_FAULT:
        if (!any_low)
          next_state = ST_HOLD;
      ST_HOLD:
        if (any_low)
          next_state = ST_FAULT;
        else if (hold_done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // hold-off counter restarts from zero on every entry
  always_ff @(posedge clk)
  begin
    if (rst || state != ST_HOLD || any_low)
      hold_cnt <= '0;
    else
      hold_cnt <= hold_cnt + 1'b1;
  end

  // run of good cycles since a filtered comparator was last low, saturating
  always_ff @(posedge clk)
  begin
    if (rst || any_low)
      good_run <= '0;
    else if (good_run != '1)
      good_run <= good_run + 1'b1;
  end

  // control bits, trip selects and enable
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_bits <= CTRL_RESET[4:0];
    else if (ctrl_wr)
      ctrl_bits <= sfr_wdata[4:0];
  end

  // low-supply flag: hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (rst)
      supply_low_flag <= CTRL_RESET[BIT_LOW_FLAG];
    else if (any_low)
      supply_low_flag <= 1'b1;
    else if (ctrl_wr)
      supply_low_flag <= sw_flag;
    else if (hold_done)
      supply_low_flag <= 1'b0;
  end

  // registered outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      digital_supply_compare <= CTRL_RESET[BIT_DIG_CMP];
      analog_supply_compare <= CTRL_RESET[BIT_ANA_CMP];
      digital_trip_select <= CTRL_RESET[BIT_DTRIP_HI:BIT_DTRIP_LO];
      analog_trip_select <= CTRL_RESET[BIT_ATRIP_HI:BIT_ATRIP_LO];
      supply_monitor_enable <= CTRL_RESET[BIT_ENABLE];
      supply_irq <= 1'b0;
      sfr_rdata <= CTRL_RESET;
    end
    else
    begin
      digital_supply_compare <= cf.dig_raw;
      analog_supply_compare <= cf.ana_raw;
      digital_trip_select <= ctrl_bits[4:3];
      analog_trip_select <= ctrl_bits[2:1];
      supply_monitor_enable <= ctrl_bits[0];
      supply_irq <= supply_low_flag & supply_irq_enable;
      sfr_rdata <= read_value;
    end
  end

  // checks on the interrupt path
  a_irq_gated: assert property (@(posedge clk) disable iff (rst)
    supply_irq |-> $past(supply_irq_enable) && $past(supply_low_flag))
    else $error("interrupt raised without enable or flag");
  a_irq_follow: assert property (@(posedge clk) disable iff (rst)
    supply_low_flag && supply_irq_enable |=> supply_irq)
    else $error("interrupt missing while flag and enable are set");
  // checks on the low-supply flag
  a_flag_on_low: assert property (@(posedge clk) disable iff (rst)
    any_low |=> supply_low_flag)
    else $error("flag not set while a comparator is low");
  a_no_sw_clear: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && !sw_flag && any_low |=> supply_low_flag)
    else $error("flag cleared during fault");
  a_sw_set: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && sw_flag |=> supply_low_flag)
    else $error("software set of the flag lost");
  a_clear_only_hold: assert property (@(posedge clk) disable iff (rst)
    $fell(supply_low_flag) |-> $past(hold_done) || $past(ctrl_wr))
    else $error("flag cleared without hold-off or write");
  a_flag_kept: assert property (@(posedge clk) disable iff (rst)
    supply_low_flag && !ctrl_wr && !hold_done |=> supply_low_flag)
    else $error("flag dropped before hold-off ended");
  // checks on the hold-off timer
  a_hold_start: assert property (@(posedge clk) disable iff (rst)
    state == ST_FAULT && !any_low |=> state == ST_HOLD && hold_cnt == '0)
    else $error("hold-off not started on recovery");
  a_hold_clear: assert property (@(posedge clk) disable iff (rst)
    hold_done && !ctrl_wr |=> !supply_low_flag)
    else $error("flag not cleared when hold-off expired");
  a_hold_abandon: assert property (@(posedge clk) disable iff (rst)
    state == ST_HOLD && any_low |=> state == ST_FAULT && hold_cnt == '0)
    else $error("hold-off not abandoned on new fault");
  a_hold_full: assert property (@(posedge clk) disable iff (rst)
    hold_done |-> good_run > HOLD_LAST)
    else $error("hold-off ended early");
  // checks on the glitch filter
  a_glitch_block: assert property (@(posedge clk) disable iff (rst)
    $fell(cf.dig_good) |-> $past(!cf.dig_raw, 1) && $past(!cf.dig_raw, 2)
    && $past(!cf.dig_raw, 3) && $past(!cf.dig_raw, 4))
    else $error("glitch passed the digital filter");
  a_glitch_ana: assert property (@(posedge clk) disable iff (rst)
    $fell(cf.ana_good) |-> $past(!cf.ana_raw, 1) && $past(!cf.ana_raw, 2)
    && $past(!cf.ana_raw, 3) && $past(!cf.ana_raw, 4))
    else $error("glitch passed the analog filter");
  // checks on the register view and the control outputs
  a_cmp_bit: assert property (@(posedge clk) disable iff (rst)
    digital_supply_compare == $past(cf.dig_raw))
    else $error("digital compare bit stale");
  a_ana_bit: assert property (@(posedge clk) disable iff (rst)
    analog_supply_compare == $past(cf.ana_raw))
    else $error("analog compare bit stale");
  a_rdata_flag: assert property (@(posedge clk) disable iff (rst)
    sfr_rdata[BIT_LOW_FLAG] == $past(supply_low_flag))
    else $error("read flag bit differs from flag");
  a_trip_sel: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> ##1 digital_trip_select == $past(sfr_wdata[4:3], 2))
    else $error("trip select not applied");
  a_ana_trip: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> ##1 analog_trip_select == $past(sfr_wdata[2:1], 2))
    else $error("analog trip select not applied");
  a_enable_bit: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> ##1 supply_monitor_enable == $past(sfr_wdata[BIT_ENABLE], 2))
    else $error("enable bit not applied");
  a_disable: assert property (@(posedge clk) disable iff (rst)
    !ctrl_bits[BIT_ENABLE] [*5] |-> !any_low)
    else $error("fault seen while the monitor is disabled");
endmodule

/* test/supply_partner.sv */
// comparator pair model: supply level in millivolts against the selected trip
`timescale 1ns/1ns
module supply_partner
  import supply_monitor_pkg::*;
(
  input wire logic [1:0] digital_trip_select,
  input wire logic [1:0] analog_trip_select,
  input wire logic [12:0] dig_mv,
  input wire logic [12:0] ana_mv,
  output logic dig_supply_cmp,
  output logic ana_supply_cmp
);
  // trip code to millivolts
  function automatic int trip_mv(input logic [1:0] sel);
    trip_mv = (sel == 2'h0) ? TRIP_00_MV : (sel == 2'h1) ? TRIP_01_MV :
      (sel == 2'h2) ? TRIP_10_MV : TRIP_11_MV;
  endfunction
  // each comparator is high while its supply is above the trip
  assign dig_supply_cmp = int'(dig_mv) > trip_mv(digital_trip_select);
  assign ana_supply_cmp = int'(ana_mv) > trip_mv(analog_trip_select);
endmodule

/* test/testbench.sv */
// self-checking bench for the supply monitor flag logic
`timescale 1ns/1ns
module testbench
  import supply_monitor_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic irq_en = 1'b0;
  logic [12:0] dig_mv = 13'h1388;
  logic [12:0] ana_mv = 13'h1388;
  logic [7:0] sfr_rdata, cfg, a;
  logic [1:0] dsel, asel;
  logic dcmp, acmp, irq, b, flag, en;
  logic [14:0] seen;
  logic [14:0] q[$];
  int fail_count = 0, n_compared = 0, cycles = 0, seed = 60;
  event look;
  always #2 clk = ~clk;
  supply_monitor_flag_logic #(.HOLD_COUNT(20)) u_supply_monitor_flag_logic (.clk(clk),
    .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rdata(sfr_rdata), .dig_supply_cmp(dcmp), .ana_supply_cmp(acmp),
    .supply_irq_enable(irq_en), .digital_trip_select(dsel), .analog_trip_select(asel),
    .supply_monitor_enable(en), .supply_low_flag(flag), .supply_irq(irq));
  // every output watched together: irq, flag, enable, trip selects, read byte
  assign seen = {irq, flag, en, dsel, asel, sfr_rdata};
  supply_partner u_supply_partner (.digital_trip_select(dsel), .analog_trip_select(asel),
    .dig_mv(dig_mv), .ana_mv(ana_mv), .dig_supply_cmp(dcmp), .ana_supply_cmp(acmp));
  // oldest note against every watched output
  always @(look)
  begin
    n_compared++;
    if (q[0] !== seen)
      $display("CHECK FAILED outputs expected %h seen %h", q[0], seen);
    if (q[0] !== seen)
      fail_count++;
    void'(q.pop_front());
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic chk(input logic i, input logic [7:0] e);
    @(negedge clk);
    q.push_back({i, e[5], e[0], e[4:1], e});
    -> look;
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    tick(5);
    rst <= 1'b0;
    chk(1'b0, CTRL_RESET);
    // every trip code with both supplies at 3.0 V, then recovery
    for (int c = 0; c < 4; c++)
    begin
      cfg = {3'h0, 2'(c), 2'(c), 1'b1};
      wr(CTRL_ADDR, 8'hc0 | cfg);
      dig_mv <= 13'h0bb8;
      ana_mv <= 13'h0bb8;
      b = c > 1;
      tick(10);
      chk(1'b0, {b, b, ~b, cfg[4:0]});
      dig_mv <= 13'h1388;
      ana_mv <= 13'h1388;
      tick(40);
      chk(1'b0, {3'h6, cfg[4:0]});
    end
    $display("test trips done");
    irq_en <= 1'b1;
    dig_mv <= 13'h0960;
    tick(10);
    chk(1'b1, {3'h3, cfg[4:0]});
    wr(CTRL_ADDR, cfg);
    tick(4);
    chk(1'b1, {3'h3, cfg[4:0]});
    dig_mv <= 13'h1388;
    tick(18);
    chk(1'b1, {3'h7, cfg[4:0]});
    dig_mv <= 13'h0960;
    tick(6);
    dig_mv <= 13'h1388;
    tick(18);
    chk(1'b1, {3'h7, cfg[4:0]});
    tick(30);
    chk(1'b0, {3'h6, cfg[4:0]});
    $display("test hold done");
    dig_mv <= 13'h0960;
    tick(2);
    dig_mv <= 13'h1388;
    tick(6);
    chk(1'b0, {3'h6, cfg[4:0]});
    wr(CTRL_ADDR, 8'h20 | cfg);
    tick(3);
    chk(1'b1, {3'h7, cfg[4:0]});
    irq_en <= 1'b0;
    tick(3);
    chk(1'b0, {3'h7, cfg[4:0]});
    wr(CTRL_ADDR, cfg);
    tick(3);
    chk(1'b0, {3'h6, cfg[4:0]});
    $display("test flag writes done");
    wr(CTRL_ADDR, cfg & 8'hfe);
    dig_mv <= 13'h0960;
    tick(10);
    chk(1'b0, {3'h6, cfg[4:1], 1'b0});
    // random writes to other addresses change nothing
    repeat (4)
    begin
      a = 8'($random(seed));
      if (a == CTRL_ADDR)
        a = 8'h00;
      wr(a, 8'($random(seed)));
    end
    tick(3);
    chk(1'b0, {3'h6, cfg[4:1], 1'b0});
    $display("test disable done");
    // mid-run reset brings every output back to its power-on value
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    chk(1'b0, CTRL_RESET);
    $display("test reset done");
    conclude();
  end
endmodule
